// ### pkg/blsrb_pkg.sv
// Functional notes
// - read: addr-write, command, addr-read, data back
// - write: addr-write, command, data stored
// - answer to address byte 0x58/0x59
// - read returns selected register, drive only then
// - brightness 256 levels, resets to 0xFF
// - brightness write ignored in PWM mode
// - brightness read ignores source selection
// - backlight on within 10 ms, off immediately
// - control bits 1,2 select operating mode
// - percent mode: brightness times duty percent
// - percent mode starts at 100 percent
// - absolute interpretation: duty ignored unless PWM mode
// - reserved control bits read zero, writes dropped
// - control resets 0x00: off, SMBus, percent
// - status bit 0 is OR of faults
// - status bit 1 shows thermal shutdown
// - status bit 3 follows backlight state
// - status bit 4: one string disabled
// - status bit 5: two strings disabled
// - status read-only, reserved zero, resets 0x00
// - over-temperature shuts down, restarts when clear
// - supply good enables, supply low shuts down
// - mode pins choose interface only; control bits choose dimming mode
// - string bits encode 00, 01, 11 fault count
package blsrb_pkg;
    localparam logic [6:0] BLSRB_DEV_ADDR = 7'h2C;
    localparam logic [7:0] BLSRB_ADDR_WR = 8'h58;
    localparam logic [7:0] BLSRB_ADDR_RD = 8'h59;
    localparam logic [7:0] BLSRB_REG_BRIGHT = 8'h00;
    localparam logic [7:0] BLSRB_REG_CTRL = 8'h01;
    localparam logic [7:0] BLSRB_REG_STATUS = 8'h02;
    localparam logic [7:0] BLSRB_BRIGHT_RST = 8'hFF;
    localparam logic [2:0] BLSRB_CTRL_RST = 3'h0;
    localparam int BLSRB_CTL_ON = 0;
    localparam int BLSRB_CTL_SEL = 1;
    localparam int BLSRB_CTL_MD = 2;
    localparam int BLSRB_ST_FAULT = 0;
    localparam int BLSRB_ST_THERM = 1;
    localparam int BLSRB_ST_OVCUR = 2;
    localparam int BLSRB_ST_BLON = 3;
    localparam int BLSRB_ST_ONE = 4;
    localparam int BLSRB_ST_MULTI = 5;
    localparam int BLSRB_CLK_HZ = 20000000;
    localparam int BLSRB_ON_DELAY_MS = 1;
    // on delay is a longest time: rounds down; kept well inside the 10 ms bound
    localparam int BLSRB_ON_CYCLES = BLSRB_CLK_HZ / 1000 * BLSRB_ON_DELAY_MS;
    localparam int BLSRB_DUTY_WIN = 256;
    localparam logic [7:0] BLSRB_DUTY_FULL = 8'hFF;

    typedef enum logic [1:0] {
        BLSRB_MODE_PCT,
        BLSRB_MODE_SMB,
        BLSRB_MODE_PWM
    } blsrb_mode_t;

    typedef struct packed {
        logic thermal;
        logic overCurrent;
        logic oneString;
        logic multiString;
        logic supplyGood;
    } blsrb_cond_t;
endpackage

// ### design/blsrb_sync.sv
`timescale 1ns/1ps
// three-stage input synchroniser; a change counts when stages two and three agree
module blsrb_sync
    import blsrb_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic din,
    output logic dout
);
    logic s1;
    logic s2;
    logic s3;

    // first stage is read by the second only; reset to the pin's idle level
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // hold the accepted level until stages two and three agree
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            dout <= RESET_VAL;
        end else if (s2 == s3) begin
            dout <= s3;
        end
    end
endmodule

// ### design/blsrb_top.sv
`timescale 1ns/1ps
module blsrb_top
    import blsrb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic smbClkIn,
    input wire logic smbDataIn,
    output logic smbDataOut,
    output logic smbDataOe,
    input wire logic pwmIn,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic thermalHot,
    input wire logic overCurrent,
    input wire logic supplyGood,
    input wire logic [7:0] stringOff,
    input wire logic [7:0] stringOpen,
    output logic [7:0] effBrightness,
    output logic backlightOn,
    output logic deviceEnable,
    output logic smbusSelected,
    output logic [7:0] statusOut
);
    logic rstMeta;
    logic rstSync_n;

    // reset released through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync_n <= rstMeta;
        end
    end

    // pin inputs pass the three-stage synchroniser; bus pins reset high so reset makes no false edge
    localparam int NSYNC = 24;
    localparam logic [NSYNC-1:0] PIN_IDLE = 24'hC00000;
    logic [NSYNC-1:0] rawPins;
    logic [NSYNC-1:0] syncPins;
    assign rawPins = {smbClkIn, smbDataIn, pwmIn, thermalHot, overCurrent, supplyGood, mode_pin_a, mode_pin_b,
        stringOff, stringOpen};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            blsrb_sync #(
                .RESET_VAL(PIN_IDLE[gi])
            ) u_sync (
                .clk(clk),
                .rstSync_n(rstSync_n),
                .din(rawPins[gi]),
                .dout(syncPins[gi])
            );
        end
    endgenerate
    logic scl;
    logic sda;
    logic pwmS;
    blsrb_cond_t cond;
    assign scl = syncPins[23];
    assign sda = syncPins[22];
    assign pwmS = syncPins[21];
    assign cond.thermal = syncPins[20];
    assign cond.overCurrent = syncPins[19];
    assign cond.supplyGood = syncPins[18];
    // string flags are independent levels, so bitwise synchronising is safe
    assign cond.oneString = |syncPins[15:8];
    assign cond.multiString = ($countones(syncPins[7:0]) >= 2);

    logic sclPrev;
    logic sdaPrev;
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sda;
        end
    end
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    assign sclRise = scl && !sclPrev;
    assign sclFall = !scl && sclPrev;
    assign startCond = scl && sclPrev && sdaPrev && !sda;
    assign stopCond = scl && sclPrev && !sdaPrev && sda;

    // serial engine
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_SEND, ST_ACK, ST_RACK
    } blsrb_state_t;
    blsrb_state_t state;
    blsrb_state_t afterAck;
    logic [2:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] cmdIdx;
    logic gotCmd;
    logic ackPending;
    logic [7:0] brightness_level;
    logic [2:0] device_control;
    logic [7:0] fault_and_state;
    logic wrStrobe;
    logic [7:0] wrData;
    logic [7:0] readValue;

    // read path: current register contents, reserved bits zero
    always_comb begin
        readValue = 8'h00;
        unique case (cmdIdx)
            BLSRB_REG_BRIGHT: readValue = brightness_level;
            BLSRB_REG_CTRL: readValue = {5'h00, device_control};
            BLSRB_REG_STATUS: readValue = fault_and_state;
            default: readValue = 8'h00;
        endcase
    end

    // byte-level protocol: address, command, then data or repeated address
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= ST_IDLE;
            afterAck <= ST_IDLE;
            bitCnt <= 3'h0;
            shiftReg <= 8'h00;
            cmdIdx <= 8'h00;
            gotCmd <= 1'b0;
            ackPending <= 1'b0;
            wrStrobe <= 1'b0;
            wrData <= 8'h00;
            smbDataOut <= 1'b1;
            smbDataOe <= 1'b0;
        end else begin
            wrStrobe <= 1'b0;
            if (stopCond) begin
                state <= ST_IDLE;
                smbDataOe <= 1'b0;
                gotCmd <= 1'b0;
            end else if (startCond) begin
                state <= ST_ADDR;
                bitCnt <= 3'h0;
                smbDataOe <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: smbDataOe <= 1'b0;
                    ST_ADDR, ST_CMD, ST_DATA: begin
                        if (sclRise) begin
                            shiftReg <= {shiftReg[6:0], sda};
                            bitCnt <= bitCnt + 3'h1;
                            if (bitCnt == 3'h7) begin
                                ackPending <= 1'b1;
                            end
                        end
                        if (sclFall && ackPending) begin
                            ackPending <= 1'b0;
                            if (state == ST_ADDR) begin
                                if (shiftReg == BLSRB_ADDR_WR) begin
                                    afterAck <= gotCmd ? ST_DATA : ST_CMD;
                                    smbDataOut <= 1'b0;
                                    smbDataOe <= 1'b1;
                                    state <= ST_ACK;
                                end else if (shiftReg == BLSRB_ADDR_RD && gotCmd) begin
                                    afterAck <= ST_SEND;
                                    smbDataOut <= 1'b0;
                                    smbDataOe <= 1'b1;
                                    state <= ST_ACK;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else if (state == ST_CMD) begin
                                cmdIdx <= shiftReg;
                                gotCmd <= 1'b1;
                                afterAck <= ST_DATA;
                                smbDataOut <= 1'b0;
                                smbDataOe <= 1'b1;
                                state <= ST_ACK;
                            end else begin
                                wrData <= shiftReg;
                                wrStrobe <= 1'b1;
                                afterAck <= ST_IDLE;
                                smbDataOut <= 1'b0;
                                smbDataOe <= 1'b1;
                                state <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        // release after the ack clock; drive only in our cycles
                        if (sclFall) begin
                            bitCnt <= 3'h0;
                            if (afterAck == ST_SEND) begin
                                shiftReg <= {readValue[6:0], 1'b0};
                                smbDataOut <= readValue[7];
                                smbDataOe <= !readValue[7];
                                state <= ST_SEND;
                            end else begin
                                smbDataOe <= 1'b0;
                                state <= afterAck;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (sclFall) begin
                            bitCnt <= bitCnt + 3'h1;
                            if (bitCnt == 3'h7) begin
                                smbDataOe <= 1'b0;
                                state <= ST_RACK;
                            end else begin
                                smbDataOut <= shiftReg[7];
                                smbDataOe <= !shiftReg[7];
                                shiftReg <= {shiftReg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RACK: begin
                        if (sclFall) begin
                            state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    blsrb_mode_t mode;
    // control bits pick the mode; select bit wins
    always_comb begin
        if (device_control[BLSRB_CTL_SEL]) begin
            mode = BLSRB_MODE_PWM;
        end else if (device_control[BLSRB_CTL_MD]) begin
            mode = BLSRB_MODE_SMB;
        end else begin
            mode = BLSRB_MODE_PCT;
        end
    end

    // mode pins: a high on either selects serial control; no open level is modelled
    logic pinsSmbus;
    assign pinsSmbus = syncPins[17] || syncPins[16];

    // register writes
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            brightness_level <= BLSRB_BRIGHT_RST;
            device_control <= BLSRB_CTRL_RST;
        end else if (wrStrobe) begin
            if (cmdIdx == BLSRB_REG_BRIGHT && mode != BLSRB_MODE_PWM) begin
                brightness_level <= wrData;
            end
            if (cmdIdx == BLSRB_REG_CTRL) begin
                device_control <= wrData[2:0];
            end
        end
    end

    // duty measurement over a 256-sample window; 100 percent until first result
    logic [7:0] winCnt;
    logic [7:0] highCnt;
    logic [7:0] dutyMeas;
    logic pctPrev;
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pctPrev <= 1'b0;
            winCnt <= 8'h00;
            highCnt <= 8'h00;
            dutyMeas <= BLSRB_DUTY_FULL;
        end else begin
            pctPrev <= (mode == BLSRB_MODE_PCT);
            // a stale pwm-mode result must not leak into a fresh percent mode
            if (mode == BLSRB_MODE_SMB || (mode == BLSRB_MODE_PCT && !pctPrev)) begin
                winCnt <= 8'h00;
                highCnt <= 8'h00;
                dutyMeas <= BLSRB_DUTY_FULL;
            end else begin
                winCnt <= winCnt + 8'h01;
                if (winCnt == 8'hFF) begin
                    // 256 high samples would wrap to zero; saturate at full scale
                    dutyMeas <= (&highCnt) ? BLSRB_DUTY_FULL : highCnt + {7'h00, pwmS};
                    highCnt <= 8'h00;
                end else begin
                    highCnt <= highCnt + {7'h00, pwmS};
                end
            end
        end
    end

    // effective brightness per mode
    logic [15:0] scaled;
    logic [7:0] next_effBrightness;
    assign scaled = brightness_level * dutyMeas;
    always_comb begin
        next_effBrightness = brightness_level;
        unique case (mode)
            BLSRB_MODE_PWM: next_effBrightness = dutyMeas;
            BLSRB_MODE_SMB: next_effBrightness = brightness_level;
            BLSRB_MODE_PCT: next_effBrightness = (dutyMeas == BLSRB_DUTY_FULL) ? brightness_level
                                                                               : scaled[15:8];
        endcase
    end

    // backlight sequencing and shutdown
    localparam int ONW = $clog2(BLSRB_ON_CYCLES + 1);
    logic [ONW-1:0] onCnt;
    logic runOk;
    assign runOk = cond.supplyGood && !cond.thermal;
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            onCnt <= '0;
            backlightOn <= 1'b0;
            deviceEnable <= 1'b0;
        end else begin
            deviceEnable <= runOk;
            if (!device_control[BLSRB_CTL_ON] || !runOk) begin
                onCnt <= '0;
                backlightOn <= 1'b0;
            end else if (onCnt == ONW'(BLSRB_ON_CYCLES - 1)) begin
                backlightOn <= 1'b1;
            end else begin
                onCnt <= onCnt + 1'b1;
            end
        end
    end

    // status follows live conditions, not latched
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fault_and_state <= 8'h00;
        end else begin
            fault_and_state <= 8'h00;
            fault_and_state[BLSRB_ST_THERM] <= cond.thermal;
            fault_and_state[BLSRB_ST_OVCUR] <= cond.overCurrent;
            fault_and_state[BLSRB_ST_BLON] <= backlightOn;
            fault_and_state[BLSRB_ST_ONE] <= cond.oneString || cond.multiString;
            fault_and_state[BLSRB_ST_MULTI] <= cond.multiString;
            fault_and_state[BLSRB_ST_FAULT] <= cond.thermal || cond.overCurrent
                || cond.oneString || cond.multiString;
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            effBrightness <= 8'h00;
            smbusSelected <= 1'b0;
            statusOut <= 8'h00;
        end else begin
            effBrightness <= backlightOn ? next_effBrightness : 8'h00;
            smbusSelected <= pinsSmbus;
            statusOut <= fault_and_state;
        end
    end
endmodule

// ### verif/blsrb_top_sva.sv
`timescale 1ns/1ps
// pin-level relations; bus timing is judged by the bench
module blsrb_top_sva
    import blsrb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic smbDataOut,
    input wire logic smbDataOe,
    input wire logic mode_pin_a,
    input wire logic mode_pin_b,
    input wire logic thermalHot,
    input wire logic supplyGood,
    input wire logic [7:0] effBrightness,
    input wire logic backlightOn,
    input wire logic deviceEnable,
    input wire logic smbusSelected,
    input wire logic [7:0] statusOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // open drain: a driven high would fight the pull-up and other devices
    pull_low_only_a: assert property (smbDataOe |-> !smbDataOut) else $error("data driven high");
    fault_summary_a: assert property (statusOut[0] == (|{statusOut[5:4], statusOut[2:1]}))
        else $error("fault bit is not the or of faults");
    status_reserved_a: assert property (statusOut[7:6] == 2'b00) else $error("reserved status set");
    string_code_a: assert property (statusOut[5] |-> statusOut[4]) else $error("string code 10");
    dark_when_off_a: assert property (!$past(backlightOn) |-> effBrightness == 8'h00)
        else $error("light while off");
    thermal_stop_a: assert property ($rose(thermalHot) |-> ##[1:8] (!deviceEnable && statusOut[1]))
        else $error("no thermal shutdown");
    thermal_restart_a: assert property (($fell(thermalHot) && supplyGood) ##1 (!thermalHot && supplyGood) [*8]
        |-> deviceEnable && !statusOut[1]) else $error("no restart after cooling");
    supply_lockout_a: assert property ($fell(supplyGood) |-> ##[1:8] !deviceEnable)
        else $error("enabled below lockout");
    light_flag_a: assert property ($changed(backlightOn) |-> ##[0:2] statusOut[3] == backlightOn)
        else $error("backlight flag stale");
    mode_strap_a: assert property (($changed(mode_pin_a) || $changed(mode_pin_b))
        |-> ##[1:8] smbusSelected == (mode_pin_a || mode_pin_b))
        else $error("interface select stale");
endmodule

bind blsrb_top blsrb_top_sva u_sva (.clk(clk), .rst_n(rst_n), .smbDataOut(smbDataOut), .smbDataOe(smbDataOe),
    .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .thermalHot(thermalHot), .supplyGood(supplyGood),
    .effBrightness(effBrightness),
    .backlightOn(backlightOn), .deviceEnable(deviceEnable), .smbusSelected(smbusSelected), .statusOut(statusOut));

// ### verif/blsrb_host_model.sv
`timescale 1ns/1ps
// smbus host; open drain, so a released line reads high through the pull-up
module blsrb_host_model
    import blsrb_pkg::*;
(
    input wire logic clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // 16-clock bit keeps scl high well past the input synchroniser delay
    task automatic bitOut(input logic b);
        sdaLow <= !b;
        tick(4);
        scl <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic bitIn(output logic b);
        sdaLow <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        #1 b = sdaLine;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask
    // also serves as repeated start, entered with scl low
    task automatic start();
        tick(1);
        sdaLow <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sdaLow <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(4);
    endtask
    task automatic stop();
        sdaLow <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sdaLow <= 1'b0;
        tick(8);
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic nb;
        for (int i = 7; i >= 0; i--) bitOut(b[i]);
        bitIn(nb);
        ack = !nb;
    endtask
    // host ends every read with a nak
    task automatic recvByte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) bitIn(b[i]);
        bitOut(1'b1);
    endtask
    task automatic wrReg(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start();
        sendByte(BLSRB_ADDR_WR, a0);
        sendByte(cmd, a1);
        sendByte(data, a2);
        stop();
        ok = a0 && a1 && a2;
    endtask
    task automatic rdReg(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start();
        sendByte(BLSRB_ADDR_WR, a0);
        sendByte(cmd, a1);
        start();
        sendByte(BLSRB_ADDR_RD, a2);
        recvByte(data);
        stop();
        ok = a0 && a1 && a2;
    endtask
endmodule

// ### verif/backlight_smbus_register_bank_tb.sv
`timescale 1ns/1ps
module backlight_smbus_register_bank_tb;
    import blsrb_pkg::*;
    logic clk, rst_n, pwmIn, mode_pin_a, mode_pin_b, thermalHot, overCurrent, supplyGood, ack;
    logic smbDataOut, smbDataOe, scl, hostLow, backlightOn, deviceEnable, smbusSelected;
    logic [7:0] stringOff, stringOpen, effBrightness, statusOut;
    wire sdaLine = !(smbDataOe || hostLow); // pull-up wins when nobody pulls low
    int n_fail = 0;
    int comparisons = 0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    blsrb_top u_dut (.clk(clk), .rst_n(rst_n), .smbClkIn(scl), .smbDataIn(sdaLine), .smbDataOut(smbDataOut),
        .smbDataOe(smbDataOe), .pwmIn(pwmIn), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
        .thermalHot(thermalHot), .overCurrent(overCurrent), .supplyGood(supplyGood), .stringOff(stringOff),
        .stringOpen(stringOpen), .effBrightness(effBrightness), .backlightOn(backlightOn),
        .deviceEnable(deviceEnable), .smbusSelected(smbusSelected), .statusOut(statusOut));
    blsrb_host_model u_host (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(hostLow));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // let the edge's updates land before looking
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        logic ok;
        u_host.wrReg(cmd, data, ok);
        check("write ack", {7'h00, ok}, 8'h01);
    endtask
    task automatic rd(input string what, input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_host.rdReg(cmd, d, ok);
        check("read ack", {7'h00, ok}, 8'h01);
        check(what, d, exp);
    endtask
    task automatic fault(input logic th, input logic oc, input logic [7:0] off, input logic [7:0] opn,
        input logic [7:0] exp);
        @(posedge clk);
        thermalHot <= th;
        overCurrent <= oc;
        stringOff <= off;
        stringOpen <= opn;
        settle(12);
        check("status pins", statusOut, exp);
        check("enable", {7'h00, deviceEnable}, {7'h00, !th});
        rd("status reg", BLSRB_REG_STATUS, exp);
    endtask
    // hang guard: about twice the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        $display("ERROR watchdog expired");
        end_of_test();
    end
    initial begin
        {rst_n, mode_pin_b, thermalHot, overCurrent, stringOff, stringOpen} = '0;
        {pwmIn, mode_pin_a, supplyGood} = 3'h7;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle(20);
        rd("bright reset", BLSRB_REG_BRIGHT, 8'hFF);
        rd("ctrl reset", BLSRB_REG_CTRL, 8'h00);
        rd("status reset", BLSRB_REG_STATUS, 8'h00);
        wr(BLSRB_REG_BRIGHT, 8'h5A);
        rd("bright write", BLSRB_REG_BRIGHT, 8'h5A);
        wr(BLSRB_REG_CTRL, 8'hFE);
        rd("ctrl reserved", BLSRB_REG_CTRL, 8'h06);
        wr(BLSRB_REG_BRIGHT, 8'h11);
        rd("bright pwm mode", BLSRB_REG_BRIGHT, 8'h5A);
        wr(BLSRB_REG_CTRL, 8'h04);
        wr(BLSRB_REG_BRIGHT, 8'h80);
        rd("bright smbus mode", BLSRB_REG_BRIGHT, 8'h80);
        wr(BLSRB_REG_STATUS, 8'hFF);
        rd("status write", BLSRB_REG_STATUS, 8'h00);
        rd("unmapped", 8'h07, 8'h00);
        // foreign address, then a read address with no command before it
        u_host.start();
        u_host.sendByte(8'h5A, ack);
        u_host.stop();
        check("foreign addr", {7'h00, ack}, 8'h00);
        u_host.start();
        u_host.sendByte(BLSRB_ADDR_RD, ack);
        u_host.stop();
        check("bare read addr", {7'h00, ack}, 8'h00);
        wr(BLSRB_REG_CTRL, 8'h05);
        for (int i = 0; i < 200000 && backlightOn !== 1'b1; i++) settle(1); // 10 ms at 20 MHz
        check("backlight on", {7'h00, backlightOn}, 8'h01);
        settle(3);
        check("on flag", statusOut & 8'h08, 8'h08);
        check("level abs", effBrightness, 8'h80);
        wr(BLSRB_REG_CTRL, 8'h01);
        settle(600);
        check("level pct full", effBrightness, 8'h80);
        @(posedge clk);
        pwmIn <= 1'b0;
        settle(800);
        check("level pct zero", effBrightness, 8'h00);
        wr(BLSRB_REG_CTRL, 8'h05);
        settle(3);
        check("level abs low duty", effBrightness, 8'h80);
        wr(BLSRB_REG_CTRL, 8'h03);
        settle(300);
        check("level pwm", effBrightness, 8'h00);
        wr(BLSRB_REG_CTRL, 8'h00);
        settle(3);
        check("backlight off", {7'h00, backlightOn}, 8'h00);
        fault(1'b1, 1'b0, 8'h00, 8'h00, 8'h03);
        fault(1'b0, 1'b1, 8'h00, 8'h00, 8'h05);
        fault(1'b0, 1'b0, 8'h01, 8'h00, 8'h11);
        fault(1'b0, 1'b0, 8'h06, 8'h06, 8'h31);
        fault(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        @(posedge clk);
        supplyGood <= 1'b0;
        mode_pin_a <= 1'b0;
        settle(12);
        check("lockout", {7'h00, deviceEnable}, 8'h00);
        check("strap low", {7'h00, smbusSelected}, 8'h00);
        @(posedge clk);
        mode_pin_b <= 1'b1;
        settle(12);
        check("strap b", {7'h00, smbusSelected}, 8'h01);
        @(posedge clk);
        supplyGood <= 1'b1;
        mode_pin_a <= 1'b1;
        settle(12);
        check("supply back", {7'h00, deviceEnable}, 8'h01);
        check("strap high", {7'h00, smbusSelected}, 8'h01);
        end_of_test();
    end
endmodule
